// *** oag_pkg.sv ***
// Package: shared constants and types for the operand address generator.
package oag_pkg;

    // ------------------------------------------------------------------
    // Addressing modes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        AM_NONE     = 4'h0,
        AM_IMM      = 4'h1,
        AM_REG_DIR  = 4'h2,
        AM_REG_IND  = 4'h3,
        AM_REG_IDX  = 4'h4,
        AM_MEM_DIR  = 4'h5,
        AM_MEM_IND  = 4'h6,
        AM_MEM_PINC = 4'h7,
        AM_MEM_PDEC = 4'h8,
        AM_MEM_IDX  = 4'h9,
        AM_MEM_LIDX = 4'hA,
        AM_BLK_MOVE = 4'hB
    } amode_t;

    // ------------------------------------------------------------------
    // Instruction classes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IC_ONE_OP = 2'h0,
        IC_TWO_AL = 2'h1,
        IC_LOAD   = 2'h2
    } iclass_t;

    // ------------------------------------------------------------------
    // Sequencer states, Gray coded from IDLE through ACCESS to UPDATE; the return to IDLE flips both bits
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ACCESS = 2'b01,
        ST_UPDATE = 2'b11
    } seq_state_t;

    localparam int          RADDR_W         = 8;
    localparam int          MADDR_W         = 16;
    localparam int          WREG_W          = 4;
    localparam logic [7:0]  RESET_WBASE     = 8'h00;
    localparam logic [15:0] PTR_STEP        = 16'h0001;
    localparam logic [7:0]  REG_STEP        = 8'h01;

endpackage

// *** oag_mode_if.sv ***
// Interface: mode pair carried between the top and the legality checker.
`timescale 1ns/10ps
interface oag_mode_if;
    oag_pkg::iclass_t iclass;
    oag_pkg::amode_t  dst_mode;
    oag_pkg::amode_t  src_mode;
    logic             is_word;
    logic             legal;

    modport top (output iclass, output dst_mode, output src_mode, output is_word,
                 input legal);
    modport chk (input iclass, input dst_mode, input src_mode, input is_word,
                 output legal);
endinterface

// *** oag_legal_check.sv ***
// Module: combinational check of the operand mode pair per instruction class.
`timescale 1ns/10ps
module oag_legal_check (
    oag_mode_if.chk m     // Mode pair in, verdict out
);

    // ------------------------------------------------------------------
    // Mode groups
    // ------------------------------------------------------------------
    function automatic logic is_reg_mem(input oag_pkg::amode_t a);
        is_reg_mem = (a == oag_pkg::AM_REG_DIR) || (a == oag_pkg::AM_REG_IND) ||
                     (a == oag_pkg::AM_MEM_IND) || (a == oag_pkg::AM_MEM_IDX) ||
                     (a == oag_pkg::AM_MEM_PINC) || (a == oag_pkg::AM_MEM_PDEC) ||
                     (a == oag_pkg::AM_MEM_DIR);
    endfunction

    function automatic logic two_op_ok(input oag_pkg::amode_t d,
                                       input oag_pkg::amode_t s);
        logic ok;
        ok = 1'b0;
        if (d == oag_pkg::AM_REG_DIR && is_reg_mem(s)) begin
            ok = 1'b1;                                           // [RULE9]
        end else if (s == oag_pkg::AM_REG_DIR && is_reg_mem(d)) begin
            ok = 1'b1;                                           // [RULE9]
        end else if (s == oag_pkg::AM_IMM && (d == oag_pkg::AM_REG_DIR ||
                     d == oag_pkg::AM_MEM_DIR || d == oag_pkg::AM_MEM_IND)) begin
            ok = 1'b1;                                           // [RULE9]
        end else if (d == oag_pkg::AM_MEM_IND && s == oag_pkg::AM_MEM_DIR) begin
            ok = 1'b1;                                           // [RULE10]
        end
        two_op_ok = ok;
    endfunction

    always_comb begin
        m.legal = 1'b0;
        case (m.iclass)
            oag_pkg::IC_ONE_OP: begin
                m.legal = (m.dst_mode == oag_pkg::AM_REG_DIR) ||
                          (m.dst_mode == oag_pkg::AM_REG_IND);   // [RULE1]
            end
            oag_pkg::IC_TWO_AL: begin
                m.legal = two_op_ok(m.dst_mode, m.src_mode);
            end
            oag_pkg::IC_LOAD: begin
                m.legal = two_op_ok(m.dst_mode, m.src_mode) ||
                          (m.dst_mode == oag_pkg::AM_REG_DIR &&
                           m.src_mode == oag_pkg::AM_REG_IDX) ||
                          (m.dst_mode == oag_pkg::AM_REG_IDX &&
                           m.src_mode == oag_pkg::AM_REG_DIR) ||
                          (m.dst_mode == oag_pkg::AM_MEM_LIDX &&
                           m.src_mode == oag_pkg::AM_IMM && m.is_word) ||  // [RULE11]
                          (m.dst_mode == oag_pkg::AM_BLK_MOVE);
            end
            default: begin
                m.legal = 1'b0;
            end
        endcase
    end

endmodule

// *** operand_address_generator.sv ***
// Module: operand address generator, resolves operand locations for the core.
`timescale 1ns/10ps
// Functional notes
// RULE1: One-operand byte ops: register direct/indirect only.
// RULE2: Immediate operand comes from instruction only.
// RULE3: Word register destination uses even pair.
// RULE4: Direct register by absolute or working number.
// RULE5: Indirect register address held in working register.
// RULE6: Indexed address is offset plus working register.
// RULE7: Indexed uses byte offset, single index.
// RULE8: Index base only from working register.
// RULE9: Two-operand pairs: direct with others, immediate sources.
// RULE10: Only memory pair: indirect destination, direct source.
// RULE11: Loads add register indexed, long-indexed immediate words.
// RULE12: Post-increment pointer after the access.
// RULE13: Pre-decrement pointer before the access.
// RULE14: Block move bumps memory and register pointers.
// RULE15: Indexed register sum wraps at eight bits.
module operand_address_generator (
    input  wire logic                  clk_i,        // Core clock, 250 MHz
    input  wire logic                  rst_i,        // Asynchronous reset, active high
    input  wire logic                  en_i,         // Clock enable, freezes state when low
    input  wire logic                  start_i,      // Decoder presents an operand request
    input  wire oag_pkg::iclass_t      iclass_i,     // Instruction class
    input  wire oag_pkg::amode_t       dst_mode_i,   // Destination addressing mode
    input  wire oag_pkg::amode_t       src_mode_i,   // Source addressing mode
    input  wire logic                  is_word_i,    // Word-sized transfer
    input  wire logic                  use_wreg_i,   // Direct operand named as working register
    input  wire logic [7:0]            abs_addr_i,   // Absolute register address field
    input  wire logic [3:0]            wreg_i,       // Working register number field
    input  wire logic [7:0]            offset_i,     // Short offset / immediate byte
    input  wire logic [15:0]           imm_i,        // Immediate word / memory address
    input  wire logic [7:0]            wbase_i,      // Base of current working set
    input  wire logic [7:0]            wreg_val_i,   // Value of named working register
    input  wire logic [15:0]           wpair_val_i,  // Value of named working register pair
    input  wire logic [7:0]            rptr_val_i,   // Register pointer for block move
    output logic                       busy_o,       // Sequence in progress
    output logic                       done_o,       // Addresses valid, one-cycle pulse
    output logic                       illegal_o,    // Mode pair refused, one-cycle pulse
    output logic                       op_is_imm_o,  // Operand value is immediate
    output logic [15:0]                imm_val_o,    // Immediate operand value
    output logic                       op_is_reg_o,  // Operand lies in register file
    output logic [7:0]                 reg_addr_o,   // Register-file address
    output logic                       reg_hi_we_o,  // Second byte of a word pair written
    output logic                       op_is_mem_o,  // Operand lies in memory
    output logic [15:0]                mem_addr_o,   // Memory address
    output logic                       ptr_we_o,     // Write back updated pair pointer
    output logic [15:0]                ptr_val_o,    // Updated pair pointer value
    output logic                       rptr_we_o,    // Write back updated register pointer
    output logic [7:0]                 rptr_val_o    // Updated register pointer value
);

    // ------------------------------------------------------------------
    // Legality check
    // ------------------------------------------------------------------
    oag_mode_if mi ();

    assign mi.iclass   = iclass_i;
    assign mi.dst_mode = dst_mode_i;
    assign mi.src_mode = src_mode_i;
    assign mi.is_word  = is_word_i;

    oag_legal_check u_chk (
        .m (mi.chk)
    );

    // ------------------------------------------------------------------
    // Address arithmetic
    // ------------------------------------------------------------------
    function automatic logic [7:0] wreg_addr(input logic [7:0] base,
                                             input logic [3:0] n);
        wreg_addr = base + {4'h0, n};
    endfunction

    // The operand that needs resolving is the one that is not plain register direct.
    oag_pkg::amode_t sel_mode;
    always_comb begin
        sel_mode = (dst_mode_i == oag_pkg::AM_REG_DIR && src_mode_i != oag_pkg::AM_NONE)
                   ? src_mode_i : dst_mode_i;
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    oag_pkg::seq_state_t state_q, state_d;
    logic                done_q, done_d;
    logic                ill_q, ill_d;
    logic                imm_q, imm_d, isreg_q, isreg_d, ismem_q, ismem_d, hi_q, hi_d;
    logic [15:0]         immv_q, immv_d, maddr_q, maddr_d, ptr_q, ptr_d;
    logic [7:0]          raddr_q, raddr_d, rptr_q, rptr_d;
    logic                ptrwe_q, ptrwe_d, rptrwe_q, rptrwe_d;
    logic                post_q, post_d, blk_q, blk_d;

    always_comb begin
        state_d  = state_q;
        done_d   = 1'b0;
        ill_d    = 1'b0;
        imm_d    = imm_q;
        isreg_d  = isreg_q;
        ismem_d  = ismem_q;
        hi_d     = hi_q;
        immv_d   = immv_q;
        maddr_d  = maddr_q;
        raddr_d  = raddr_q;
        ptr_d    = ptr_q;
        rptr_d   = rptr_q;
        ptrwe_d  = 1'b0;
        rptrwe_d = 1'b0;
        post_d   = post_q;
        blk_d    = blk_q;
        case (state_q)
            oag_pkg::ST_IDLE: begin
                if (start_i && !mi.legal) begin
                    ill_d = 1'b1;
                end else if (start_i) begin
                    imm_d   = 1'b0;
                    isreg_d = 1'b0;
                    ismem_d = 1'b0;
                    hi_d    = 1'b0;
                    post_d  = 1'b0;
                    blk_d   = 1'b0;
                    state_d = oag_pkg::ST_ACCESS;
                    case (sel_mode)
                        oag_pkg::AM_IMM: begin
                            imm_d  = 1'b1;                                  // [RULE2]
                            immv_d = is_word_i ? imm_i : {8'h00, offset_i}; // [RULE2]
                            hi_d = is_word_i && dst_mode_i == oag_pkg::AM_REG_DIR;
                            raddr_d = use_wreg_i ? wreg_addr(wbase_i, wreg_i) : abs_addr_i;
                            raddr_d[0] &= !hi_d; // [RULE3]
                        end
                        oag_pkg::AM_REG_DIR: begin
                            isreg_d = 1'b1;
                            raddr_d = use_wreg_i ? wreg_addr(wbase_i, wreg_i)
                                                 : abs_addr_i;              // [RULE4]
                            if (is_word_i) begin
                                raddr_d[0] = 1'b0;                          // [RULE3]
                                hi_d       = 1'b1;                          // [RULE3]
                            end
                        end
                        oag_pkg::AM_REG_IND: begin
                            isreg_d = 1'b1;
                            raddr_d = wreg_val_i;                           // [RULE5]
                        end
                        oag_pkg::AM_REG_IDX: begin
                            isreg_d = 1'b1;
                            // Byte offset plus one working register, carry dropped.
                            raddr_d = 8'(offset_i + wreg_val_i);    // [RULE6] [RULE7] [RULE8] [RULE15]
                        end
                        oag_pkg::AM_MEM_DIR: begin
                            ismem_d = 1'b1;
                            maddr_d = imm_i;
                        end
                        oag_pkg::AM_MEM_IND: begin
                            ismem_d = 1'b1;
                            maddr_d = wpair_val_i;
                        end
                        oag_pkg::AM_MEM_PINC: begin
                            ismem_d = 1'b1;
                            maddr_d = wpair_val_i;                          // [RULE12]
                            ptr_d   = wpair_val_i + oag_pkg::PTR_STEP;
                            post_d  = 1'b1;
                        end
                        oag_pkg::AM_MEM_PDEC: begin
                            ismem_d = 1'b1;
                            ptr_d   = wpair_val_i - oag_pkg::PTR_STEP;      // [RULE13]
                            maddr_d = wpair_val_i - oag_pkg::PTR_STEP;      // [RULE13]
                            ptrwe_d = 1'b1;                                 // [RULE13]
                        end
                        oag_pkg::AM_MEM_IDX: begin
                            ismem_d = 1'b1;
                            maddr_d = wpair_val_i + {8'h00, offset_i};
                        end
                        oag_pkg::AM_MEM_LIDX: begin
                            ismem_d = 1'b1;
                            maddr_d = wpair_val_i + imm_i;
                        end
                        oag_pkg::AM_BLK_MOVE: begin
                            ismem_d = 1'b1;
                            isreg_d = 1'b1;
                            maddr_d = wpair_val_i;
                            raddr_d = rptr_val_i;
                            ptr_d   = wpair_val_i + oag_pkg::PTR_STEP;
                            rptr_d  = rptr_val_i + oag_pkg::REG_STEP;
                            blk_d   = 1'b1;
                        end
                        default: begin
                            state_d = oag_pkg::ST_IDLE;
                            ill_d   = 1'b1;
                        end
                    endcase
                end
            end
            oag_pkg::ST_ACCESS: begin
                // Addresses are presented now; post-increment and block-move pointer updates follow the access.
                done_d  = 1'b1;
                state_d = oag_pkg::ST_UPDATE;
            end
            oag_pkg::ST_UPDATE: begin
                ptrwe_d  = post_q || blk_q;                                 // [RULE12] [RULE14]
                rptrwe_d = blk_q;                                           // [RULE14]
                state_d  = oag_pkg::ST_IDLE;
            end
            default: begin
                state_d = oag_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q  <= oag_pkg::ST_IDLE;
            done_q   <= 1'b0;
            ill_q    <= 1'b0;
            imm_q    <= 1'b0;
            isreg_q  <= 1'b0;
            ismem_q  <= 1'b0;
            hi_q     <= 1'b0;
            immv_q   <= 16'h0000;
            maddr_q  <= 16'h0000;
            raddr_q  <= 8'h00;
            ptr_q    <= 16'h0000;
            rptr_q   <= 8'h00;
            ptrwe_q  <= 1'b0;
            rptrwe_q <= 1'b0;
            post_q   <= 1'b0;
            blk_q    <= 1'b0;
        end else if (en_i) begin
            state_q  <= state_d;
            done_q   <= done_d;
            ill_q    <= ill_d;
            imm_q    <= imm_d;
            isreg_q  <= isreg_d;
            ismem_q  <= ismem_d;
            hi_q     <= hi_d;
            immv_q   <= immv_d;
            maddr_q  <= maddr_d;
            raddr_q  <= raddr_d;
            ptr_q    <= ptr_d;
            rptr_q   <= rptr_d;
            ptrwe_q  <= ptrwe_d;
            rptrwe_q <= rptrwe_d;
            post_q   <= post_d;
            blk_q    <= blk_d;
        end
    end

    assign busy_o      = (state_q != oag_pkg::ST_IDLE);
    assign done_o      = done_q;
    assign illegal_o   = ill_q;
    assign op_is_imm_o = imm_q;
    assign imm_val_o   = immv_q;
    assign op_is_reg_o = isreg_q;
    assign reg_addr_o  = raddr_q;
    assign reg_hi_we_o = hi_q;
    assign op_is_mem_o = ismem_q;
    assign mem_addr_o  = maddr_q;
    assign ptr_we_o    = ptrwe_q;
    assign ptr_val_o   = ptr_q;
    assign rptr_we_o   = rptrwe_q;
    assign rptr_val_o  = rptr_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_one_op_modes: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
        (en_i && state_q == oag_pkg::ST_IDLE && start_i && iclass_i == oag_pkg::IC_ONE_OP &&
         dst_mode_i == oag_pkg::AM_MEM_DIR) |=> ill_q)
        else $error("one-operand memory mode not refused");
    a_imm_only: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
        imm_q |-> !isreg_q && !ismem_q)
        else $error("immediate operand also flagged as register or memory");
    a_word_even: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
        hi_q |-> raddr_q[0] == 1'b0)
        else $error("word register pair not even");
    a_idx_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE15]
        (en_i && state_q == oag_pkg::ST_IDLE && start_i && mi.legal &&
         sel_mode == oag_pkg::AM_REG_IDX) |=> raddr_q == 8'($past(offset_i) + $past(wreg_val_i)))
        else $error("indexed register address wrong");
    a_ind_addr: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
        (en_i && state_q == oag_pkg::ST_IDLE && start_i && mi.legal &&
         sel_mode == oag_pkg::AM_REG_IND) |=> raddr_q == $past(wreg_val_i))
        else $error("indirect register address wrong");
    a_post_inc: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
        (en_i && done_q && post_q) |=> ptr_we_o && ptr_val_o == mem_addr_o + 16'h0001)
        else $error("post-increment not after access");
    a_pre_dec: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
        (ptr_we_o && state_q == oag_pkg::ST_ACCESS) |-> ptr_val_o == mem_addr_o)
        else $error("pre-decrement address differs from pointer");
    a_blk_move: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
        rptr_we_o |-> ptr_we_o && rptr_val_o == reg_addr_o + 8'h01)
        else $error("block move pointers not both bumped");

endmodule

// *** oag_rf_model.sv ***
// Behavioural register-file model that answers the operand address generator.
`timescale 1ns/10ps
module oag_rf_model (
    input  wire logic        clk_i,        // Core clock
    input  wire logic [7:0]  wbase_i,      // Base of current working set
    input  wire logic [3:0]  wreg_i,       // Named working register
    input  wire logic [3:0]  rreg_i,       // Working register used as register pointer
    input  wire logic        ptr_we_i,     // Pair pointer write back
    input  wire logic [15:0] ptr_val_i,    // Pair pointer value
    input  wire logic        rptr_we_i,    // Register pointer write back
    input  wire logic [7:0]  rptr_val_i,   // Register pointer value
    output logic      [7:0]  wreg_val_o,   // Contents of named working register
    output logic      [15:0] wpair_val_o,  // Contents of named working pair
    output logic      [7:0]  rptr_val_o    // Contents of register pointer
);
    logic [7:0] mem [256];
    logic [7:0] wa;
    logic [7:0] pa;
    logic [7:0] ra;

    // Pairs always start on an even register, high byte first.
    assign wa = wbase_i + {4'h0, wreg_i};
    assign pa = {wa[7:1], 1'b0};
    assign ra = wbase_i + {4'h0, rreg_i};

    always_comb begin
        wreg_val_o  = mem[wa];
        wpair_val_o = {mem[pa], mem[pa | 8'h01]};
        rptr_val_o  = mem[ra];
    end

    always @(posedge clk_i) begin
        if (ptr_we_i) begin
            mem[pa]          <= ptr_val_i[15:8];
            mem[pa | 8'h01]  <= ptr_val_i[7:0];
        end
        if (rptr_we_i) begin
            mem[ra] <= rptr_val_i;
        end
    end

    // Address-dependent fill (i XOR A5) so that a wrong pick of register shows up.
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end

    task automatic poke(input logic [7:0] a, input logic [7:0] d);
        mem[a] = d;
    endtask
endmodule

// *** tb.sv ***
// Self-checking testbench of the operand address generator.
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, en_i = 1'b1, start_i = 1'b0;
    oag_pkg::iclass_t iclass_i = oag_pkg::IC_ONE_OP;
    oag_pkg::amode_t  dst_mode_i = oag_pkg::AM_NONE, src_mode_i = oag_pkg::AM_NONE;
    logic is_word_i = 1'b0, use_wreg_i = 1'b0;
    logic [7:0]  abs_addr_i = 8'h00, offset_i = 8'h00, wbase_i = 8'h30;
    logic [3:0]  wreg_i = 4'h0, rreg_i = 4'h6;
    logic [15:0] imm_i = 16'h0000, wpair_val_i, ptr_val_o, imm_val_o, mem_addr_o, p1_val, p3_val;
    logic [7:0]  wreg_val_i, rptr_val_i, reg_addr_o, rptr_val_o, r3_val;
    logic busy_o, done_o, illegal_o, op_is_imm_o, op_is_reg_o, reg_hi_we_o, op_is_mem_o;
    logic ptr_we_o, rptr_we_o, s_ill, s_done, p1_we, p3_we, r3_we;
    int   failures = 0, n_checks = 0, cycles = 0;

    always #2 clk_i = ~clk_i;

    operand_address_generator DUT (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i), .start_i(start_i),
        .iclass_i(iclass_i), .dst_mode_i(dst_mode_i), .src_mode_i(src_mode_i),
        .is_word_i(is_word_i), .use_wreg_i(use_wreg_i), .abs_addr_i(abs_addr_i),
        .wreg_i(wreg_i), .offset_i(offset_i), .imm_i(imm_i), .wbase_i(wbase_i),
        .wreg_val_i(wreg_val_i), .wpair_val_i(wpair_val_i), .rptr_val_i(rptr_val_i),
        .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .op_is_imm_o(op_is_imm_o),
        .imm_val_o(imm_val_o), .op_is_reg_o(op_is_reg_o), .reg_addr_o(reg_addr_o),
        .reg_hi_we_o(reg_hi_we_o), .op_is_mem_o(op_is_mem_o), .mem_addr_o(mem_addr_o),
        .ptr_we_o(ptr_we_o), .ptr_val_o(ptr_val_o), .rptr_we_o(rptr_we_o),
        .rptr_val_o(rptr_val_o));

    oag_rf_model rf (.clk_i(clk_i), .wbase_i(wbase_i), .wreg_i(wreg_i), .rreg_i(rreg_i),
        .ptr_we_i(ptr_we_o), .ptr_val_i(ptr_val_o), .rptr_we_i(rptr_we_o),
        .rptr_val_i(rptr_val_o), .wreg_val_o(wreg_val_i), .wpair_val_o(wpair_val_i),
        .rptr_val_o(rptr_val_i));

    // ------------------------------------------------------------------
    // Shared request task
    // ------------------------------------------------------------------
    // One request walks the whole sequence so no request lands while busy.
    task automatic go(input oag_pkg::iclass_t ic, input oag_pkg::amode_t d,
                      input oag_pkg::amode_t s, input logic w);
        @(posedge clk_i);
        iclass_i <= ic; dst_mode_i <= d; src_mode_i <= s; is_word_i <= w; start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        #1 s_ill = illegal_o; p1_we = ptr_we_o; p1_val = ptr_val_o;
        @(posedge clk_i);
        #1 s_done = done_o;
        @(posedge clk_i);
        #1 p3_we = ptr_we_o; p3_val = ptr_val_o; r3_we = rptr_we_o; r3_val = rptr_val_o;
        @(posedge clk_i) #1;
    endtask

    task automatic lg(input oag_pkg::iclass_t ic, input oag_pkg::amode_t d,
                      input oag_pkg::amode_t s, input logic w, input logic ok);
        go(ic, d, s, w);
        `CHK(s_ill, ~ok)
        `CHK(s_done, ok)
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_imm_word();
        @(posedge clk_i); abs_addr_i <= 8'h43; imm_i <= 16'h1234; use_wreg_i <= 1'b0;
        go(oag_pkg::IC_TWO_AL, oag_pkg::AM_REG_DIR, oag_pkg::AM_IMM, 1'b1);
        `CHK(op_is_imm_o, 1'b1)
        `CHK(imm_val_o, 16'h1234)
        `CHK(reg_hi_we_o, 1'b1)
        `CHK(reg_addr_o, 8'h42)
    endtask

    task automatic t_direct();
        @(posedge clk_i); abs_addr_i <= 8'hA2;
        go(oag_pkg::IC_ONE_OP, oag_pkg::AM_REG_DIR, oag_pkg::AM_NONE, 1'b0);
        `CHK(reg_addr_o, 8'hA2)
        `CHK(op_is_reg_o, 1'b1)
        @(posedge clk_i); use_wreg_i <= 1'b1; wreg_i <= 4'h4;
        go(oag_pkg::IC_ONE_OP, oag_pkg::AM_REG_DIR, oag_pkg::AM_NONE, 1'b0);
        `CHK(reg_addr_o, 8'h34)
    endtask

    task automatic t_indirect();
        @(posedge clk_i); wreg_i <= 4'hB; rf.poke(8'h3B, 8'h56);
        go(oag_pkg::IC_ONE_OP, oag_pkg::AM_REG_IND, oag_pkg::AM_NONE, 1'b0);
        `CHK(reg_addr_o, 8'h56)
    endtask

    task automatic t_indexed();
        @(posedge clk_i); wreg_i <= 4'hA; offset_i <= 8'h28; rf.poke(8'h3A, 8'h37);
        go(oag_pkg::IC_LOAD, oag_pkg::AM_REG_DIR, oag_pkg::AM_REG_IDX, 1'b0);
        `CHK(reg_addr_o, 8'h5F)
        `CHK(op_is_mem_o, 1'b0)
        @(posedge clk_i); offset_i <= 8'h20; rf.poke(8'h3A, 8'hF0);
        go(oag_pkg::IC_LOAD, oag_pkg::AM_REG_DIR, oag_pkg::AM_REG_IDX, 1'b0);
        `CHK(reg_addr_o, 8'h10)
    endtask

    task automatic t_pointers();
        @(posedge clk_i); wreg_i <= 4'h4; rf.poke(8'h34, 8'h30); rf.poke(8'h35, 8'h00);
        go(oag_pkg::IC_LOAD, oag_pkg::AM_REG_DIR, oag_pkg::AM_MEM_PINC, 1'b0);
        `CHK(mem_addr_o, 16'h3000)
        `CHK({p1_we, p3_we}, 2'b01)
        `CHK(wpair_val_i, 16'h3001)
        rf.poke(8'h34, 8'h11); rf.poke(8'h35, 8'h11);
        go(oag_pkg::IC_LOAD, oag_pkg::AM_REG_DIR, oag_pkg::AM_MEM_PDEC, 1'b0);
        `CHK({p1_we, p1_val}, {1'b1, 16'h1110})
        `CHK(mem_addr_o, 16'h1110)
        @(posedge clk_i); wreg_i <= 4'h2; rf.poke(8'h32, 8'h20); rf.poke(8'h33, 8'h00);
        rf.poke(8'h36, 8'h44);
        go(oag_pkg::IC_LOAD, oag_pkg::AM_BLK_MOVE, oag_pkg::AM_NONE, 1'b0);
        `CHK({p3_we, p3_val}, {1'b1, 16'h2001})
        `CHK({r3_we, r3_val}, {1'b1, 8'h45})
    endtask

    task automatic t_legality();
        lg(oag_pkg::IC_ONE_OP, oag_pkg::AM_REG_IND, oag_pkg::AM_NONE, 1'b0, 1'b1);
        lg(oag_pkg::IC_ONE_OP, oag_pkg::AM_MEM_DIR, oag_pkg::AM_NONE, 1'b0, 1'b0);
        lg(oag_pkg::IC_ONE_OP, oag_pkg::AM_IMM, oag_pkg::AM_NONE, 1'b0, 1'b0);
        lg(oag_pkg::IC_TWO_AL, oag_pkg::AM_REG_DIR, oag_pkg::AM_MEM_PINC, 1'b0, 1'b1);
        lg(oag_pkg::IC_TWO_AL, oag_pkg::AM_MEM_DIR, oag_pkg::AM_IMM, 1'b0, 1'b1);
        lg(oag_pkg::IC_TWO_AL, oag_pkg::AM_MEM_IDX, oag_pkg::AM_IMM, 1'b0, 1'b0);
        lg(oag_pkg::IC_TWO_AL, oag_pkg::AM_MEM_IND, oag_pkg::AM_MEM_DIR, 1'b0, 1'b1);
        lg(oag_pkg::IC_TWO_AL, oag_pkg::AM_MEM_DIR, oag_pkg::AM_MEM_IND, 1'b0, 1'b0);
        lg(oag_pkg::IC_TWO_AL, oag_pkg::AM_REG_DIR, oag_pkg::AM_REG_IDX, 1'b0, 1'b0);
        lg(oag_pkg::IC_LOAD, oag_pkg::AM_REG_IDX, oag_pkg::AM_REG_DIR, 1'b0, 1'b1);
        lg(oag_pkg::IC_LOAD, oag_pkg::AM_MEM_LIDX, oag_pkg::AM_IMM, 1'b1, 1'b1);
        lg(oag_pkg::IC_LOAD, oag_pkg::AM_MEM_LIDX, oag_pkg::AM_IMM, 1'b0, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Closing report and hang guard
    // ------------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 `CHK({busy_o, done_o, op_is_reg_o, ptr_we_o}, 4'h0)
        t_imm_word();
        t_direct();
        t_indirect();
        t_indexed();
        t_pointers();
        t_legality();
        wrap_up();
    end
endmodule
